/* File: include/brc_map.svh */
`ifndef BRC_MAP_SVH
`define BRC_MAP_SVH
// ==========================================================
// csr byte offsets
`define BRC_OFF_BIT_SET 19'h7_FFFB
`define BRC_OFF_BIT_CLEAR 19'h7_FFF7
`define BRC_OFF_OWNER 19'h7_FFF3
`define BRC_OFF_RCW_BASE 19'h7_FF60
`define BRC_OFF_UBEG 19'h0_0053
`define BRC_OFF_UEND 19'h0_005F
// ==========================================================
// field positions
`define BRC_BIT_ENABLE 4
`define BRC_BIT_OWNED 2
`define BRC_BIT_DYN_READ 1
`define BRC_BIT_XAM 0
// ==========================================================
// codes and reset values
`define BRC_AM_XAM_LO 6'h20
`define BRC_AM_XAM_HI 6'h21
`define BRC_OWNER_FREE 8'h00
`define BRC_RCW_RESET 32'h0000_0000
`endif

/* File: include/brc_pkg.sv */
`default_nettype none
package brc_pkg;
    typedef logic [31:0] brc_word_t;
    typedef logic [7:0] brc_byte_t;
    typedef logic [18:0] brc_addr_t;
    typedef logic [5:0] brc_am_t;
    typedef logic [23:0] brc_ptr_t;
endpackage : brc_pkg
`default_nettype wire

/* File: logic/brc_relocation_csr.sv */
`include "brc_map.svh"
`default_nettype none
module brc_relocation_csr #(
    parameter int NUM_FUNC = 8,
    parameter logic [NUM_FUNC*32-1:0] DECODE_MASK = {NUM_FUNC{32'hFFFF_0000}},
    parameter logic [NUM_FUNC-1:0] XAM_AM_SEL = '0,
    parameter logic [NUM_FUNC-1:0] DYN_SIZE = '0,
    parameter logic [NUM_FUNC-1:0] FIXED_ADDR = '0,
    parameter logic SPECIAL_EN = 1'b0,
    parameter logic [5:0] SPECIAL_AM = 6'h00,
    parameter logic [23:0] USER_ROM_BEGIN = 24'h00_0000,
    parameter logic [23:0] USER_ROM_END = 24'h00_0000
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // configuration-space byte port
    input wire brc_pkg::brc_addr_t csr_addr,
    input wire brc_pkg::brc_byte_t csr_wdata,
    input wire logic csr_we,
    input wire logic csr_re,
    output logic [7:0] csr_rdata,
    output logic csr_ack,
    // bus cycle to decode
    input wire logic bus_strobe,
    input wire brc_pkg::brc_word_t bus_addr,
    input wire brc_pkg::brc_am_t bus_am,
    input wire logic bus_xam_valid,
    input wire brc_pkg::brc_byte_t bus_xam,
    // fixed switch settings
    input wire logic [NUM_FUNC*32-1:0] fixed_compare,
    // decode results
    output logic [NUM_FUNC-1:0] func_select,
    output logic decode_enable
);
    import brc_pkg::*;

    localparam int IW = (NUM_FUNC > 1) ? $clog2(NUM_FUNC) : 1;

    // ==========================================================
    // address decode
    brc_byte_t owner_id;
    logic owned;
    brc_addr_t rcw_off;
    logic rcw_hit;
    logic [IW-1:0] rcw_idx;
    logic [1:0] rcw_byte;
    logic wr_set;
    logic wr_clear;
    logic wr_owner;
    logic wr_rcw;
    brc_word_t cw [NUM_FUNC];
    logic dyn_read [NUM_FUNC];
    wire logic [NUM_FUNC-1:0] next_select;

    assign owned = (owner_id != `BRC_OWNER_FREE);
    assign rcw_off = csr_addr - `BRC_OFF_RCW_BASE;
    assign rcw_hit = (csr_addr >= `BRC_OFF_RCW_BASE) && (rcw_off < 19'(NUM_FUNC * 16)) && (rcw_off[1:0] == 2'b11);
    assign rcw_idx = rcw_off[IW+3:4];
    assign rcw_byte = rcw_off[3:2];
    assign wr_set = csr_we && (csr_addr == `BRC_OFF_BIT_SET);
    assign wr_clear = csr_we && (csr_addr == `BRC_OFF_BIT_CLEAR);
    assign wr_owner = csr_we && (csr_addr == `BRC_OFF_OWNER);
    assign wr_rcw = csr_we && rcw_hit;

    // ==========================================================
    // decoder enable
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            decode_enable <= 1'b0;
        else if (wr_set && csr_wdata[`BRC_BIT_ENABLE])
            decode_enable <= 1'b1;
        else if (wr_clear && csr_wdata[`BRC_BIT_ENABLE])
            decode_enable <= 1'b0;
    end

    // ==========================================================
    // ownership semaphore; set register bit 2 is ignored
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            owner_id <= `BRC_OWNER_FREE;
        else if (wr_clear && csr_wdata[`BRC_BIT_OWNED])
            owner_id <= `BRC_OWNER_FREE;
        else if (wr_owner && !owned)
            owner_id <= csr_wdata;
    end

    // ==========================================================
    // compare words and matching, one per function
    for (genvar i = 0; i < NUM_FUNC; i++)
    begin : g_func
        localparam brc_word_t MASK = DECODE_MASK[i*32 +: 32];
        logic hit_ext;
        logic hit_norm;
        logic sel;

        always_ff @(posedge clk_sys)
        begin
            if (!reset_n)
                cw[i] <= `BRC_RCW_RESET;
            else if (FIXED_ADDR[i])
                cw[i] <= fixed_compare[i*32 +: 32];
            else if (wr_rcw && rcw_idx == IW'(i) && MASK != '0)
            begin
                case (rcw_byte)
                    2'd0: cw[i][31:24] <= csr_wdata;
                    2'd1: cw[i][23:16] <= csr_wdata;
                    2'd2: cw[i][15:8] <= csr_wdata;
                    default: cw[i][7:0] <= csr_wdata;
                endcase
            end
        end

        always_ff @(posedge clk_sys)
        begin
            if (!reset_n)
                dyn_read[i] <= 1'b0;
            else if (wr_rcw && rcw_idx == IW'(i) && rcw_byte == 2'd3)
                dyn_read[i] <= DYN_SIZE[i] & csr_wdata[`BRC_BIT_DYN_READ];
        end

        // extended: compare 31:10, extended code in 9:2 on base code
        assign hit_ext = ((bus_addr[31:10] & MASK[31:10]) == (cw[i][31:10] & MASK[31:10]))
            && bus_xam_valid && (bus_xam == cw[i][9:2])
            && (bus_am == (XAM_AM_SEL[i] ? `BRC_AM_XAM_HI : `BRC_AM_XAM_LO));
        // ordinary: compare 31:8, code in 7:2
        assign hit_norm = ((bus_addr[31:8] & MASK[31:8]) == (cw[i][31:8] & MASK[31:8]))
            && !bus_xam_valid
            && ((bus_am == cw[i][7:2]) || (SPECIAL_EN && bus_am == SPECIAL_AM));
        assign sel = cw[i][`BRC_BIT_XAM] ? hit_ext : hit_norm;

        assign next_select[i] = bus_strobe && decode_enable && (MASK != '0) && sel;
    end

    // one register for all select bits, so the output has a single driver
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            func_select <= '0;
        else
            func_select <= next_select;
    end

    // ==========================================================
    // read path
    brc_byte_t next_rdata;
    brc_word_t rd_word;

    always_comb
    begin
        next_rdata = 8'h00;
        rd_word = 32'h0000_0000;
        if (csr_addr == `BRC_OFF_BIT_SET || csr_addr == `BRC_OFF_BIT_CLEAR)
        begin
            next_rdata[`BRC_BIT_ENABLE] = decode_enable;
            next_rdata[`BRC_BIT_OWNED] = owned;
        end
        else if (csr_addr == `BRC_OFF_OWNER)
            next_rdata = owner_id;
        else if (rcw_hit)
        begin
            for (int k = 0; k < NUM_FUNC; k++)
            begin
                if (rcw_idx == IW'(k))
                begin
                    rd_word = cw[k];
                    if (dyn_read[k] && cw[k][`BRC_BIT_XAM])
                        rd_word = {DECODE_MASK[k*32+10 +: 22], cw[k][9:0]};
                    else if (dyn_read[k])
                        rd_word = {DECODE_MASK[k*32+8 +: 24], cw[k][7:0]};
                end
            end
            case (rcw_byte)
                2'd0: next_rdata = rd_word[31:24];
                2'd1: next_rdata = rd_word[23:16];
                2'd2: next_rdata = rd_word[15:8];
                default: next_rdata = rd_word[7:0];
            endcase
        end
        else if (csr_addr == `BRC_OFF_UBEG)
            next_rdata = USER_ROM_BEGIN[23:16];
        else if (csr_addr == `BRC_OFF_UBEG + 19'h0_0004)
            next_rdata = USER_ROM_BEGIN[15:8];
        else if (csr_addr == `BRC_OFF_UBEG + 19'h0_0008)
            next_rdata = USER_ROM_BEGIN[7:0];
        else if (csr_addr == `BRC_OFF_UEND)
            next_rdata = USER_ROM_END[23:16];
        else if (csr_addr == `BRC_OFF_UEND + 19'h0_0004)
            next_rdata = USER_ROM_END[15:8];
        else if (csr_addr == `BRC_OFF_UEND + 19'h0_0008)
            next_rdata = USER_ROM_END[7:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            csr_rdata <= 8'h00;
        else if (csr_re)
            csr_rdata <= next_rdata;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            csr_ack <= 1'b0;
        else
            csr_ack <= csr_re || csr_we;
    end

    // ==========================================================
    // checks
    a_owner_sticky: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_owner && owned && !wr_clear) |=> (owner_id == $past(owner_id)))
        else $error("owner changed while held");
    a_clear_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_clear && csr_wdata[2]) |=> (owner_id == 8'h00) && !owned)
        else $error("clear did not release owner");
    a_set_ignored: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_set && csr_wdata[2]) |=> (owner_id == $past(owner_id)))
        else $error("set bit 2 changed owner");
    a_status_owned: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (csr_re && csr_addr == `BRC_OFF_BIT_CLEAR) |=> (csr_rdata[2] == ($past(owner_id) != 8'h00)))
        else $error("owned status misreported");
    a_enable_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_set && csr_wdata[4]) |=> decode_enable ##0 csr_ack)
        else $error("enable not set");
    a_enable_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_clear && csr_wdata[4]) |=> !decode_enable)
        else $error("enable not cleared");
    a_select_enable: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !decode_enable |=> (func_select == '0))
        else $error("select while disabled");
    a_owner_reset: assert property (@(posedge clk_sys)
        !reset_n |=> (owner_id == 8'h00) && !decode_enable)
        else $error("reset did not clear state");
    c_acquire: cover property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_owner && !owned) ##1 owned ##[1:20] (wr_clear && csr_wdata[2]));
    c_select: cover property (@(posedge clk_sys) disable iff (!reset_n) |func_select);
    c_dyn: cover property (@(posedge clk_sys) disable iff (!reset_n) wr_rcw && csr_wdata[1]);
endmodule : brc_relocation_csr
`default_nettype wire

/* File: bench/brc_master_model.sv */
`default_nettype none
// ==========================================================
// configuring master: byte accesses on the register port
module brc_master_model (
    // clock
    input wire logic clk_sys,
    // register port
    output brc_pkg::brc_addr_t csr_addr,
    output brc_pkg::brc_byte_t csr_wdata,
    output logic csr_we,
    output logic csr_re,
    input wire logic [7:0] csr_rdata,
    input wire logic csr_ack,
    // raised when no answer came
    output logic hang
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        csr_addr = '0;
        csr_wdata = '0;
        csr_we = 1'b0;
        csr_re = 1'b0;
        hang = 1'b0;
    end
    task automatic access(input logic wr, input brc_pkg::brc_addr_t a, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(negedge clk_sys);
        csr_addr = a;
        csr_wdata = d;
        csr_we = wr;
        csr_re = !wr;
        @(negedge clk_sys);
        csr_we = 1'b0;
        csr_re = 1'b0;
        n = 0;
        while (csr_ack !== 1'b1 && n < 4)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 4)
            hang = 1'b1;
        q = csr_rdata;
        csr_wdata = ~d;
    endtask : access
endmodule : brc_master_model
`default_nettype wire

/* File: bench/bus_slave_relocation_csr_test.sv */
`include "brc_map.svh"
`default_nettype none
module bus_slave_relocation_csr_test;
    timeunit 1ns;
    timeprecision 1ns;
    import brc_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    brc_addr_t csr_addr;
    brc_byte_t csr_wdata, bus_xam = 8'h00;
    logic csr_we, csr_re, csr_ack, hang, decode_enable, bus_strobe = 1'b0, bus_xam_valid = 1'b0;
    logic [7:0] csr_rdata;
    brc_word_t bus_addr = 32'h0000_0000;
    brc_am_t bus_am = 6'h00;
    logic [2:0] func_select;
    logic [95:0] fixed_compare = {32'hA000_0124, 64'h0000_0000_0000_0000};
    int err_total = 0;
    int num_checks = 0;
    always #50 clk_sys = ~clk_sys;
    brc_master_model i_master (.clk_sys(clk_sys), .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_we(csr_we),
        .csr_re(csr_re), .csr_rdata(csr_rdata), .csr_ack(csr_ack), .hang(hang));
    brc_relocation_csr #(.NUM_FUNC(3), .DECODE_MASK({32'hFFFF_FF00, 32'hFF00_0000, 32'hFFFF_0000}),
        .DYN_SIZE(3'b001), .FIXED_ADDR(3'b100), .SPECIAL_EN(1'b1), .SPECIAL_AM(6'h05),
        .USER_ROM_BEGIN(24'h00_1000)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .csr_addr(csr_addr),
        .csr_wdata(csr_wdata), .csr_we(csr_we), .csr_re(csr_re), .csr_rdata(csr_rdata), .csr_ack(csr_ack),
        .bus_strobe(bus_strobe), .bus_addr(bus_addr), .bus_am(bus_am), .bus_xam_valid(bus_xam_valid),
        .bus_xam(bus_xam), .fixed_compare(fixed_compare), .func_select(func_select),
        .decode_enable(decode_enable));
    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    always @(posedge hang)
    begin
        err_total++;
        results();
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk8
    task automatic wr(input brc_addr_t a, input logic [7:0] d);
        logic [7:0] q;
        i_master.access(1'b1, a, d, q);
    endtask : wr
    task automatic chk_rd(input brc_addr_t a, input logic [7:0] exp);
        logic [7:0] q;
        i_master.access(1'b0, a, 8'h00, q);
        chk8(q, exp);
    endtask : chk_rd
    // whole word, msb byte first; never the configuration-space code
    task automatic wr_word(input int n, input brc_word_t w);
        for (int i = 0; i < 4; i++)
            wr(19'h7_FF63 + 19'(16 * n + 4 * i), w[31 - 8 * i -: 8]);
    endtask : wr_word
    task automatic chk_bus(input brc_word_t a, input brc_am_t am, input logic xv, input logic [7:0] x,
        input logic [2:0] exp);
        @(negedge clk_sys);
        bus_strobe = 1'b1;
        bus_addr = a;
        bus_am = am;
        bus_xam_valid = xv;
        bus_xam = x;
        @(negedge clk_sys);
        bus_strobe = 1'b0;
        bus_addr = ~a;
        chk8({5'h00, func_select}, {5'h00, exp});
    endtask : chk_bus
    task automatic t_reset();
        chk_rd(`BRC_OFF_OWNER, 8'h00);
        chk_rd(`BRC_OFF_BIT_CLEAR, 8'h00);
        chk8({7'h00, decode_enable}, 8'h00);
    endtask : t_reset
    task automatic t_owner();
        wr(`BRC_OFF_BIT_SET, 8'h04);
        chk_rd(`BRC_OFF_BIT_SET, 8'h00);
        wr(`BRC_OFF_OWNER, 8'h05);
        chk_rd(`BRC_OFF_BIT_SET, 8'h04);
        wr(`BRC_OFF_OWNER, 8'h09);
        chk_rd(`BRC_OFF_OWNER, 8'h05);
        wr(`BRC_OFF_BIT_SET, 8'h04);
        chk_rd(`BRC_OFF_OWNER, 8'h05);
        wr(`BRC_OFF_BIT_CLEAR, 8'h04);
        chk_rd(`BRC_OFF_BIT_CLEAR, 8'h00);
        chk_rd(`BRC_OFF_OWNER, 8'h00);
    endtask : t_owner
    task automatic t_decode();
        wr_word(0, 32'h1234_0024);
        chk_bus(32'h1234_5678, 6'h09, 1'b0, 8'h00, 3'b000);
        wr(`BRC_OFF_BIT_SET, 8'h10);
        chk_rd(`BRC_OFF_BIT_CLEAR, 8'h10);
        chk8({7'h00, decode_enable}, 8'h01);
        chk_bus(32'h1234_5678, 6'h09, 1'b0, 8'h00, 3'b001);
        chk_bus(32'h1234_5678, 6'h0A, 1'b0, 8'h00, 3'b000);
        chk_bus(32'h1235_5678, 6'h09, 1'b0, 8'h00, 3'b000);
        chk_bus(32'h1234_5678, 6'h05, 1'b0, 8'h00, 3'b001);
        chk_bus(32'hA000_0140, 6'h09, 1'b0, 8'h00, 3'b100);
        chk_bus(32'hA000_0040, 6'h09, 1'b0, 8'h00, 3'b000);
    endtask : t_decode
    task automatic t_xam();
        wr_word(1, 32'h5600_0309);
        chk_rd(19'h7_FF7F, 8'h09);
        chk_bus(32'h5612_3456, 6'h20, 1'b1, 8'hC2, 3'b010);
        chk_bus(32'h5612_3456, 6'h20, 1'b1, 8'h02, 3'b000);
        chk_bus(32'h5612_3456, 6'h21, 1'b1, 8'hC2, 3'b000);
        wr(`BRC_OFF_BIT_CLEAR, 8'h10);
        chk_bus(32'h5612_3456, 6'h20, 1'b1, 8'hC2, 3'b000);
    endtask : t_xam
    // switch-set word of function 2 reads back and ignores writes
    task automatic t_fixed();
        chk_rd(19'h7_FF83, 8'hA0);
        wr(19'h7_FF83, 8'h55);
        chk_rd(19'h7_FF83, 8'hA0);
        chk_rd(19'h7_FF8B, 8'h01);
    endtask : t_fixed
    task automatic t_dyn();
        wr(19'h7_FF6F, 8'h26);
        chk_rd(19'h7_FF63, 8'hFF);
        chk_rd(19'h7_FF67, 8'hFF);
        wr(19'h7_FF6F, 8'h24);
        chk_rd(19'h7_FF63, 8'h12);
    endtask : t_dyn
    task automatic t_misc();
        chk_rd(19'h7_FF00, 8'h00);
        chk_rd(19'h0_0057, 8'h10);
        chk_rd(19'h0_0053, 8'h00);
    endtask : t_misc
    initial
    begin
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        reset_n = 1'b1;
        t_reset();
        t_fixed();
        t_owner();
        t_decode();
        t_xam();
        t_dyn();
        t_misc();
        results();
    end
endmodule : bus_slave_relocation_csr_test
`default_nettype wire
